// >>> core/rng_gate_defines.vh
// constants for the random number output gate and its health tests
`ifndef RNG_GATE_DEFINES_VH
`define RNG_GATE_DEFINES_VH

// ==========================================================
// controller states
`define ST_IDLE 2'h0
`define ST_STARTUP 2'h1
`define ST_RUN 2'h2
`define ST_FAIL 2'h3

// ==========================================================
// total failure test: identical raw bits in a row that count as a dead source
`define TF_LIMIT 6'h20
// delay line length in raw bits, equal to the total failure limit
`define DELAY_LEN 32

// ==========================================================
// online monobit test over a window of raw bits
`define WIN_LAST 8'hff
`define WIN_ONES_LO 9'h064
`define WIN_ONES_HI 9'h09c

// ==========================================================
// word assembly: last bit index for 8 and 16 bit words
`define LAST_BIT_8 5'h07
`define LAST_BIT_16 5'h0f
`define WORD_W 16

`endif

// >>> core/pair_buffer.v
// two-entry valid/ready buffer with registered outputs and a flush
module pair_buffer #(
   parameter WIDTH = 16
) (
   input wire clk,
   input wire reset,
   input wire flush,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   // ==========================================================
   // storage
   reg [WIDTH-1:0] head_q; // word presented to the consumer
   reg head_v_q;
   reg [WIDTH-1:0] tail_q; // overflow word while the consumer stalls
   reg tail_v_q;

   wire take_in; // word accepted this cycle
   wire take_out; // word consumed this cycle

   // ready only depends on a flop, so no combinational path back to the source
   assign in_ready = ~tail_v_q;
   assign out_data = head_q;
   assign out_valid = head_v_q;
   assign take_in = in_valid & ~tail_v_q;
   assign take_out = head_v_q & out_ready;

   // ==========================================================
   // head and tail update
   always @(posedge clk) begin
      if (reset || flush) begin
         // flush drops stored words so nothing outlives a failure
         head_v_q <= 1'b0;
         tail_v_q <= 1'b0;
         head_q <= {WIDTH{1'b0}};
         tail_q <= {WIDTH{1'b0}};
      end else begin
         if (!head_v_q || take_out) begin
            // head free next cycle: refill from tail first, keeping order
            if (tail_v_q) begin
               head_q <= tail_q;
               head_v_q <= 1'b1;
               tail_v_q <= take_in;
               if (take_in) begin
                  tail_q <= in_data;
               end
            end else begin
               head_v_q <= take_in;
               if (take_in) begin
                  head_q <= in_data;
               end
            end
         end else if (take_in) begin
            // head stalled: park the new word in the tail
            tail_q <= in_data;
            tail_v_q <= 1'b1;
         end
      end
   end
endmodule // pair_buffer

// >>> core/physical_rng_health_gate.v
// output gate and health tests for a physical random number generator
`include "rng_gate_defines.vh"

module physical_rng_health_gate (
   input wire clk,
   input wire reset,
   input wire raw_bit, // raw entropy bit from the analog source, asynchronous
   input wire start, // one-cycle pulse: (re)start the generator
   input wire word16, // word size taken at start: 1 = 16 bit, 0 = 8 bit
   input wire rnd_ready, // consumer takes the word this cycle
   output wire [15:0] rnd_data, // random word, 8 bit words in the low byte
   output wire rnd_valid, // random word present
   output reg gen_ok, // startup test passed, generator running
   output reg err_total, // sticky: entropy source dead
   output reg err_stat // sticky: statistical defect or repeated word
);
   // ==========================================================
   // declarations
   reg raw_s1_q; // first synchroniser stage, read only by raw_s2_q
   reg raw_s2_q; // synchronised raw bit
   reg [1:0] state_q; // controller state
   reg [1:0] state_d;
   reg word16_q; // word size latched at start
   reg last_bit_q; // previous raw bit for the repetition test
   reg [5:0] rep_cnt_q; // length of the current run of equal bits
   reg [7:0] win_cnt_q; // position in the monobit window
   reg [8:0] ones_q; // ones seen so far in the window
   reg [`DELAY_LEN-1:0] delay_q; // raw bits held back before word assembly
   reg [15:0] word_q; // word being assembled
   reg [4:0] bit_cnt_q; // bits already in word_q
   reg word_full_q; // word_q complete, waiting for the buffer
   reg [15:0] prev_word_q; // last word handed to the buffer
   reg prev_ok_q; // prev_word_q holds a word since start

   wire testing; // health tests active
   wire tf_hit; // total failure seen this cycle
   wire [8:0] ones_end; // window ones count including this bit
   wire win_end; // last bit of a window
   wire stat_hit; // window out of bounds
   wire rep_word; // finished word equals the previous one
   wire fail_now; // any defect this cycle
   wire buf_ready; // buffer accepts a word
   wire push; // hand finished word to the buffer
   wire flush; // empty the buffer
   wire [4:0] last_idx; // index of the last bit for this word size

   // ==========================================================
   // raw bit synchroniser
   always @(posedge clk) begin
      if (reset) begin
         raw_s1_q <= 1'b0;
         raw_s2_q <= 1'b0;
      end else begin
         raw_s1_q <= raw_bit;
         raw_s2_q <= raw_s1_q;
      end
   end

   // tests rest in the start cycle, so no defect can race the flag clear
   assign testing = ((state_q == `ST_STARTUP) || (state_q == `ST_RUN)) && !start;

   // ==========================================================
   // total failure test: a run of identical bits marks a dead source
   // the run counter starts fresh at start, so a stuck source trips
   // within the startup window, before any word is released
   assign tf_hit = testing && (raw_s2_q == last_bit_q)
      && (rep_cnt_q == `TF_LIMIT - 6'h01);

   always @(posedge clk) begin
      if (reset || start) begin
         last_bit_q <= 1'b0;
         rep_cnt_q <= 6'h00;
      end else if (testing) begin
         last_bit_q <= raw_s2_q;
         if (raw_s2_q == last_bit_q && rep_cnt_q != 6'h00) begin
            rep_cnt_q <= rep_cnt_q + 6'h01;
         end else begin
            rep_cnt_q <= 6'h01; // new run begins with this bit
         end
      end
   end

   // ==========================================================
   // online monobit test over fixed windows, running for ever
   // detection can take up to two windows of raw bits when a defect starts mid-window
   assign ones_end = ones_q + {8'h00, raw_s2_q};
   assign win_end = testing && (win_cnt_q == `WIN_LAST);
   assign stat_hit = win_end && ((ones_end < `WIN_ONES_LO)
      || (ones_end > `WIN_ONES_HI));

   always @(posedge clk) begin
      if (reset || start) begin
         win_cnt_q <= 8'h00;
         ones_q <= 9'h000;
      end else if (testing) begin
         win_cnt_q <= win_cnt_q + 8'h01; // wraps, next window starts
         if (win_end) begin
            ones_q <= 9'h000;
         end else begin
            ones_q <= ones_end;
         end
      end
   end

   // ==========================================================
   // delay line: a bit reaches assembly only after the failure test
   // has seen as many later bits as its limit, so any bit made after
   // the onset of a dead source is still held back when the alarm fires
   always @(posedge clk) begin
      if (reset || start) begin
         delay_q <= {`DELAY_LEN{1'b0}};
      end else if (testing) begin
         delay_q <= {delay_q[`DELAY_LEN-2:0], raw_s2_q};
      end
   end

   // ==========================================================
   // word assembly and the repeated-word test
   assign last_idx = word16_q ? `LAST_BIT_16 : `LAST_BIT_8;
   assign rep_word = testing && word_full_q && prev_ok_q && (word_q == prev_word_q);
   assign fail_now = tf_hit || stat_hit || rep_word;
   // only a running, healthy generator may hand a word on
   assign push = (state_q == `ST_RUN) && word_full_q && !fail_now;
   assign flush = (state_d != `ST_RUN);

   always @(posedge clk) begin
      if (reset || start || state_q != `ST_RUN) begin
         word_q <= 16'h0000;
         bit_cnt_q <= 5'h00;
         word_full_q <= 1'b0;
      end else if (word_full_q) begin
         // a stalled consumer holds the word; raw bits pass by unused
         if (push && buf_ready) begin
            word_q <= 16'h0000;
            bit_cnt_q <= 5'h00;
            word_full_q <= 1'b0;
         end
      end else begin
         word_q <= {word_q[14:0], delay_q[`DELAY_LEN-1]};
         bit_cnt_q <= bit_cnt_q + 5'h01;
         word_full_q <= (bit_cnt_q == last_idx);
      end
   end

   // remember the last word released for the repeated-word test
   always @(posedge clk) begin
      if (reset || start) begin
         prev_word_q <= 16'h0000;
         prev_ok_q <= 1'b0;
      end else if (push && buf_ready) begin
         prev_word_q <= word_q;
         prev_ok_q <= 1'b1;
      end
   end

   // ==========================================================
   // controller: idle, startup test, run, fail
   always @* begin
      state_d = state_q;
      case (state_q)
         `ST_IDLE: begin
            if (start) begin
               state_d = `ST_STARTUP;
            end
         end
         `ST_STARTUP: begin
            if (start) begin
               state_d = `ST_STARTUP;
            end else if (fail_now) begin
               state_d = `ST_FAIL;
            end else if (win_end) begin
               state_d = `ST_RUN; // first window passed
            end
         end
         `ST_RUN: begin
            if (start) begin
               state_d = `ST_STARTUP;
            end else if (fail_now) begin
               state_d = `ST_FAIL;
            end
         end
         `ST_FAIL: begin
            if (start) begin
               state_d = `ST_STARTUP; // only a restart leaves fail
            end
         end
         default: begin
            state_d = `ST_IDLE;
         end
      endcase
   end

   always @(posedge clk) begin
      if (reset) begin
         state_q <= `ST_IDLE;
         word16_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (start) begin
            word16_q <= word16;
         end
      end
   end

   // ==========================================================
   // status flags: sticky until a restart; a defect in the start cycle
   // cannot occur because tests are idle then, so no set/clear race
   always @(posedge clk) begin
      if (reset || start) begin
         err_total <= 1'b0;
         err_stat <= 1'b0;
         gen_ok <= 1'b0;
      end else begin
         if (tf_hit) begin
            err_total <= 1'b1;
         end
         if (stat_hit || rep_word) begin
            err_stat <= 1'b1;
         end
         gen_ok <= (state_d == `ST_RUN);
      end
   end

   // ==========================================================
   // output buffer; flushed whenever the generator is not running
   pair_buffer #(
      .WIDTH(`WORD_W)
   ) u_out_buf (
      .clk(clk),
      .reset(reset),
      .flush(flush),
      .in_data(word_q),
      .in_valid(push),
      .in_ready(buf_ready),
      .out_data(rnd_data),
      .out_valid(rnd_valid),
      .out_ready(rnd_ready)
   );
endmodule // physical_rng_health_gate

// >>> bench/rng_gate_chk.sv
// port checker for the random number output gate
module rng_gate_chk (
   input wire clk,
   input wire reset,
   input wire raw_bit,
   input wire start,
   input wire word16,
   input wire rnd_ready,
   input wire [15:0] rnd_data,
   input wire rnd_valid,
   input wire gen_ok,
   input wire err_total,
   input wire err_stat
);
   timeunit 1ns;
   timeprecision 1ps;
   // =========================================
   // helper state
   logic mode16_q; // word size taken at start
   logic [9:0] since_q; // cycles since start, saturating
   logic [5:0] run_q; // equal raw bits seen while running
   logic last_q; // previous raw bit
   // track start and raw runs; runs count only while running
   always @(posedge clk) begin
      if (reset) begin
         mode16_q <= 1'b0;
         since_q <= 10'h000;
         run_q <= 6'h00;
         last_q <= 1'b0;
      end else begin
         last_q <= raw_bit;
         if (start) begin
            mode16_q <= word16;
            since_q <= 10'h001;
         end else if (since_q != 10'h000 && since_q != 10'h3ff) begin
            since_q <= since_q + 10'h001;
         end
         if (!gen_ok || raw_bit != last_q) begin
            run_q <= 6'h00;
         end else if (run_q != 6'h3f) begin
            run_q <= run_q + 6'h01;
         end
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // =========================================
   // assertions
   sequence s_stall;
      rnd_valid && !rnd_ready && !start;
   endsequence
   sequence s_calm;
      !err_total && !err_stat && !start;
   endsequence
   a_valid_needs_ok: assert property (rnd_valid |-> gen_ok)
      else $error("word offered while generator not running");
   a_startup_wait: assert property (gen_ok |-> since_q < 10'h003 || since_q >= 10'h100)
      else $error("running before startup window ended");
   a_total_sticky: assert property (err_total && !start |=> err_total)
      else $error("dead source flag dropped");
   a_stat_sticky: assert property (err_stat && !start |=> err_stat)
      else $error("defect flag dropped");
   a_err_stops_ok: assert property ((err_total || err_stat) && !start |=> !gen_ok)
      else $error("running with an error flag");
   a_err_stops_out: assert property ((err_total || err_stat) && !start |=> !rnd_valid)
      else $error("word offered after a failure");
   a_stall_hold: assert property (s_stall ##1 s_calm |-> rnd_valid && $stable(rnd_data))
      else $error("stalled word changed or lost");
   a_byte_high_zero: assert property (rnd_valid && !mode16_q |-> rnd_data[15:8] == 8'h00)
      else $error("high byte set in byte mode");
   a_dead_bound: assert property (run_q == 6'h28 |-> err_total)
      else $error("stuck source not flagged in time");
endmodule // rng_gate_chk

bind physical_rng_health_gate rng_gate_chk chk (.clk(clk), .reset(reset), .raw_bit(raw_bit),
   .start(start), .word16(word16), .rnd_ready(rnd_ready), .rnd_data(rnd_data),
   .rnd_valid(rnd_valid), .gen_ok(gen_ok), .err_total(err_total), .err_stat(err_stat));

// >>> bench/rng_consumer.sv
// model of the bus master that collects random words
module rng_consumer (
   input wire clk,
   input wire reset,
   input wire stall,
   input wire err_any,
   input wire rnd_valid,
   input wire [15:0] rnd_data,
   output logic rnd_ready,
   output int taken,
   output logic hi_seen
);
   timeunit 1ns;
   timeprecision 1ps;
   // take words only while offered; use them only with no error raised
   always @(posedge clk) begin
      if (reset) begin
         rnd_ready <= 1'b0;
         taken <= 0;
         hi_seen <= 1'b0;
      end else begin
         rnd_ready <= !stall;
         if (rnd_valid && rnd_ready) begin
            taken <= taken + 1;
            if (!err_any && rnd_data[15:8] != 8'h00) hi_seen <= 1'b1;
         end
      end
   end
endmodule // rng_consumer

// >>> bench/test_physical_rng_health_gate.sv
// self-checking bench for the random number output gate
module test_physical_rng_health_gate;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin miscompares++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
   logic clk = 0, reset = 1, raw_bit = 0, start = 0, word16 = 0, stall = 0, hi_seen;
   wire [15:0] rnd_data;
   wire rnd_valid, gen_ok, err_total, err_stat, rnd_ready;
   int taken, miscompares = 0, checks = 0, cycles = 0;
   logic [1:0] src = 2'h0, ph = 2'h0; // raw source kind, phase
   logic [15:0] lfsr = 16'hace1;
   // period nine: an 8 bit word takes nine cycles, so every word repeats
   logic [8:0] pat = 9'h0b5;
   physical_rng_health_gate uut (.clk(clk), .reset(reset), .raw_bit(raw_bit), .start(start),
      .word16(word16), .rnd_ready(rnd_ready), .rnd_data(rnd_data), .rnd_valid(rnd_valid),
      .gen_ok(gen_ok), .err_total(err_total), .err_stat(err_stat));
   rng_consumer far (.clk(clk), .reset(reset), .stall(stall), .err_any(err_total | err_stat),
      .rnd_valid(rnd_valid), .rnd_data(rnd_data), .rnd_ready(rnd_ready), .taken(taken),
      .hi_seen(hi_seen));
   initial forever #20 clk = ~clk;
   // =========================================
   // raw source: good, stuck, biased or periodic; plus the hang limit
   always @(posedge clk) begin
      lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      pat <= {pat[7:0], pat[8]};
      ph <= ph + 2'h1;
      case (src)
         2'h0: raw_bit <= lfsr[0];
         2'h1: raw_bit <= 1'b1;
         2'h2: raw_bit <= (ph == 2'h0); // a quarter ones fails the window
         default: raw_bit <= pat[8];
      endcase
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         give_verdict();
      end
   end
   // =========================================
   // tasks
   task automatic tick(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic kick(logic w);
      @(posedge clk);
      start <= 1'b1;
      word16 <= w;
      @(posedge clk);
      start <= 1'b0;
   endtask
   task automatic t_idle; // no start: nothing may come out
      tick(300);
      `CHK("valid", 1'b0, rnd_valid)
      `CHK("ok", 1'b0, gen_ok)
      `CHK("errs", 2'h0, {err_total, err_stat})
   endtask
   task automatic t_fail_start(logic [1:0] s);
      int n;
      n = taken;
      src <= s;
      kick(1'b0);
      tick(400);
      `CHK("flags", {s == 2'h1, s == 2'h2}, {err_total, err_stat})
      `CHK("ok", 1'b0, gen_ok)
      `CHK("no words", 1'b1, taken == n)
   endtask
   task automatic t_run(logic w);
      int n;
      src <= 2'h0;
      kick(w);
      n = 0;
      while (!gen_ok && n < 400) begin
         tick(1);
         n++;
      end
      `CHK("startup", 1'b1, n >= 250 && n < 300)
      `CHK("errs", 2'h0, {err_total, err_stat})
      stall <= 1'b1;
      tick(80);
      `CHK("held", 1'b1, rnd_valid)
      n = taken;
      stall <= 1'b0;
      tick(100);
      `CHK("words", 1'b1, taken - n >= 4)
      `CHK("wide", w, hi_seen)
   endtask
   task automatic t_break(logic [1:0] s); // failure while running
      src <= s;
      tick(100);
      `CHK("flags", {s == 2'h1, s == 2'h3}, {err_total, err_stat})
      `CHK("valid", 1'b0, rnd_valid)
      `CHK("ok", 1'b0, gen_ok)
   endtask
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // =========================================
   // main sequence
   initial begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      t_idle();
      t_fail_start(2'h1);
      t_fail_start(2'h2);
      t_run(1'b0);
      t_break(2'h3);
      t_run(1'b1);
      t_break(2'h1);
      give_verdict();
   end
endmodule // test_physical_rng_health_gate
